// >>> include/xlate_fault_pkg.sv
/*
  Constants for the I/O translation fault handler: flag positions in the
  error status vector, page-size codes, translation mode codes and the
  default widths of the logged fault fields.
  Assumes a single clock domain and no software-visible register bus.
*/
package xlate_fault_pkg;

  // Error status flag positions
  localparam int FLAG_KEY_PROT     = 0;
  localparam int FLAG_MODE_ERR     = 1;
  localparam int FLAG_OUT_OF_RANGE = 2;
  localparam int FLAG_ENTRY_INV    = 3;
  localparam int FLAG_ENTRY_PROT   = 4;
  localparam int FLAG_CACHE_PAR    = 5;
  localparam int FLAG_CACHE_ACC    = 6;
  localparam int FLAG_WALK_OFF     = 7;
  localparam int FLAG_WALK_UNEXP   = 8;
  localparam int FLAG_WALK_ERR     = 9;
  localparam int FLAG_WALK_PAR     = 10;
  localparam int FLAG_BAD_PAGE     = 11;
  localparam int NUM_FLAGS         = 12;

  // Legal page-size codes in hypervisor translation mode
  localparam logic [2:0] PAGE_8K   = 3'h0;
  localparam logic [2:0] PAGE_64K  = 3'h1;
  localparam logic [2:0] PAGE_4M   = 3'h3;
  localparam logic [2:0] PAGE_256M = 3'h5;

  // Translation mode select
  localparam logic MODE_LEGACY     = 1'h0;
  localparam logic MODE_HYPERVISOR = 1'h1;

  // Default widths of logged fields
  localparam int ADDR_WIDTH = 64;
  localparam int ID_WIDTH   = 16;
  localparam int TYPE_WIDTH = 7;
  localparam int RAM_WIDTH  = 9;

  // Address bit that survives an illegal page-size fault
  localparam int DESC_SELECT_BIT = 63;

  // Reset values
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 12'h000;

endpackage

// >>> verilog/io_translation_fault_handler.sv
/*
  Error detection, logging and response for an I/O address translation unit.
  Each DMA translation outcome is classified into fault flags, the fault is
  logged (address, requester ID, type; table RAM address only for entry protection and cache parity faults), the request is
  answered one cycle later (write dropped, read given Completer Abort), and
  a maskable interrupt is raised. Cache register-port accesses are checked
  against the cache enable.
  Assumes all inputs come from logic on sys_clk; flag clear and mask vectors
  are driven by a register block outside this module.
*/
// Behaviour
// - Every detected translation error raises an interrupt request software can mask.
// - Faulting DMA write is discarded; faulting read completes with Completer Abort.
// - Log raw address in legacy mode, adjusted address in hypervisor mode.
// - Each logged fault captures requester ID and transaction type.
// - Key protection failure sets its flag, logs address and ID, aborts.
// - Request in an erroneous translation mode sets mode flag, logs, aborts.
// - Translated address outside configured range sets range flag, logs, aborts.
// - Invalid table entry sets invalid-entry flag, logs, aborts.
// - Entry denying access sets protection flag, logs ID, type, RAM address, aborts.
// - Cache data parity error sets flag, logs address, ID, type, RAM address, aborts.
// - Register-port cache access while enabled sets flag; write fails, read errors.
// - Cache miss with tablewalk disabled sets disabled-miss flag, logs, aborts.
// - Tablewalk unexpected data sets its flag, logs address, ID, type, aborts.
// - Tablewalk failure and tablewalk parity set separate flags; each logs, aborts.
// - Hypervisor mode accepts page codes 0,1,3,5 only; others flag and abort.
// - For bad page size, address bits 39:13 meaningless; bit 63 and ID locate it.
`timescale 1ns/1ps

module io_translation_fault_handler #(
  parameter int ADDR_W = xlate_fault_pkg::ADDR_WIDTH,
  parameter int ID_W   = xlate_fault_pkg::ID_WIDTH,
  parameter int TYPE_W = xlate_fault_pkg::TYPE_WIDTH,
  parameter int RAM_W  = xlate_fault_pkg::RAM_WIDTH
) (
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst,
  // Translation result of one DMA request
  input  wire logic                                 req_valid,
  input  wire logic                                 req_write,
  input  wire logic                                 req_mode,
  input  wire logic [ADDR_W-1:0]                    req_raw_va,
  input  wire logic [ADDR_W-1:0]                    req_adj_va,
  input  wire logic [ID_W-1:0]                      req_id,
  input  wire logic [TYPE_W-1:0]                    req_type,
  input  wire logic [RAM_W-1:0]                     req_ram_addr,
  input  wire logic [2:0]                           req_page_size,
  input  wire logic                                 key_check_fail,
  input  wire logic                                 mode_in_error,
  input  wire logic                                 range_exceeded,
  input  wire logic                                 entry_invalid,
  input  wire logic                                 entry_denied,
  input  wire logic                                 cache_parity_err,
  input  wire logic                                 cache_miss,
  input  wire logic                                 walk_enable,
  input  wire logic                                 walk_unexpected,
  input  wire logic                                 walk_failed,
  input  wire logic                                 walk_parity_err,
  // Register-port access to the translation cache
  input  wire logic                                 xcache_req,
  input  wire logic                                 xcache_write,
  input  wire logic                                 xcache_enabled,
  // Flag control from the register block
  input  wire logic [xlate_fault_pkg::NUM_FLAGS-1:0] err_clear,
  input  wire logic [xlate_fault_pkg::NUM_FLAGS-1:0] err_mask,
  // Answer to the DMA request
  output logic                                      resp_valid,
  output logic                                      resp_abort,
  output logic                                      resp_write_drop,
  output logic                                      resp_cpl_abort,
  // Answer to the cache register-port access
  output logic                                      xcache_done,
  output logic                                      xcache_access_fault,
  // Status and log
  output logic [xlate_fault_pkg::NUM_FLAGS-1:0]     err_status,
  output logic [ADDR_W-1:0]                         fault_addr,
  output logic [ID_W-1:0]                           fault_req_id,
  output logic [TYPE_W-1:0]                         fault_type,
  output logic [RAM_W-1:0]                          fault_ram_addr,
  output logic                                      fault_logged,
  output logic                                      irq
);

  localparam int NF = xlate_fault_pkg::NUM_FLAGS;

  // Address bit 63 is part of the illegal page-size report, so narrower
  // addresses cannot be served.
  generate
    if (ADDR_W != xlate_fault_pkg::ADDR_WIDTH) begin : g_bad_addr_w
      $error("ADDR_W must equal 64");
    end
    if (ID_W < 1 || TYPE_W < 1 || RAM_W < 1) begin : g_bad_field_w
      $error("ID_W, TYPE_W and RAM_W must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic              resp_valid;
    logic              resp_abort;
    logic              resp_write_drop;
    logic              resp_cpl_abort;
    logic              xcache_done;
    logic              xcache_access_fault;
    logic [NF-1:0]     flags;
    logic [ADDR_W-1:0] addr;
    logic [ID_W-1:0]   id;
    logic [TYPE_W-1:0] typ;
    logic [RAM_W-1:0]  ram;
    logic              logged;
    logic              irq;
  } state_s;

  state_s state;
  state_s next_state;

  logic [NF-1:0]     detect;
  logic              page_ok;
  logic              dma_fault;
  logic              ram_logged;
  logic [ADDR_W-1:0] log_addr;
  logic [NF-1:0]     flags_after;

  // Page-size legality; only the hypervisor mode carries a size code
  always_comb begin
    case (req_page_size)
      xlate_fault_pkg::PAGE_8K:   page_ok = 1'b1;
      xlate_fault_pkg::PAGE_64K:  page_ok = 1'b1;
      xlate_fault_pkg::PAGE_4M:   page_ok = 1'b1;
      xlate_fault_pkg::PAGE_256M: page_ok = 1'b1;
      default:                    page_ok = 1'b0;
    endcase
  end

  // Classify the request outcome into fault flags
  always_comb begin
    detect = '0;
    if (req_valid) begin
      detect[xlate_fault_pkg::FLAG_KEY_PROT]     = key_check_fail;
      detect[xlate_fault_pkg::FLAG_MODE_ERR]     = mode_in_error;
      detect[xlate_fault_pkg::FLAG_OUT_OF_RANGE] = range_exceeded;
      detect[xlate_fault_pkg::FLAG_ENTRY_INV]    = entry_invalid;
      detect[xlate_fault_pkg::FLAG_ENTRY_PROT]   = entry_denied;
      detect[xlate_fault_pkg::FLAG_CACHE_PAR]    = cache_parity_err;
      detect[xlate_fault_pkg::FLAG_WALK_OFF]     = cache_miss & ~walk_enable;
      detect[xlate_fault_pkg::FLAG_WALK_UNEXP]   = walk_unexpected;
      detect[xlate_fault_pkg::FLAG_WALK_ERR]     = walk_failed;
      detect[xlate_fault_pkg::FLAG_WALK_PAR]     = walk_parity_err;
      detect[xlate_fault_pkg::FLAG_BAD_PAGE]     =
        (req_mode == xlate_fault_pkg::MODE_HYPERVISOR) & ~page_ok;
    end
    // Cache register-port access is not a DMA request and logs no address
    detect[xlate_fault_pkg::FLAG_CACHE_ACC] = xcache_req & xcache_enabled;
  end

  // Any DMA-side fault; the cache access flag is excluded on purpose
  always_comb begin
    dma_fault = |(detect & ~(NF'(1) << xlate_fault_pkg::FLAG_CACHE_ACC));
    ram_logged = detect[xlate_fault_pkg::FLAG_ENTRY_PROT] |
                 detect[xlate_fault_pkg::FLAG_CACHE_PAR];
  end

  // Address to log follows the active translation mode
  always_comb begin
    if (req_mode == xlate_fault_pkg::MODE_HYPERVISOR) begin
      log_addr = req_adj_va;
    end else begin
      log_addr = req_raw_va;
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle
  always_comb begin
    flags_after = (state.flags & ~err_clear) | detect;
  end

  // Next-state logic
  always_comb begin
    next_state = state;

    // Answers are one-cycle pulses
    next_state.resp_valid          = req_valid;
    next_state.resp_abort          = req_valid & dma_fault;
    next_state.resp_write_drop     = req_valid & dma_fault & req_write;
    next_state.resp_cpl_abort      = req_valid & dma_fault & ~req_write;
    next_state.xcache_done         = xcache_req;
    next_state.xcache_access_fault = xcache_req & xcache_enabled;

    next_state.flags = flags_after;

    // Latest fault overwrites the log; the flags keep the history
    if (dma_fault) begin
      // For a bad page size, bits 39:13 are kept as captured but carry no
      // meaning; software uses bit 63 and the requester ID instead.
      next_state.addr   = log_addr;
      next_state.id     = req_id;
      next_state.typ    = req_type;
      next_state.logged = 1'b1;
      if (ram_logged) begin
        next_state.ram = req_ram_addr;
      end else begin
        next_state.ram = '0;
      end
    end

    // Log valid falls when every flag has been cleared
    if (flags_after == '0) begin
      next_state.logged = 1'b0;
    end

    // Interrupt level from flags after this cycle's set and clear
    next_state.irq = |(flags_after & err_mask);
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state        <= '0;
      state.flags  <= xlate_fault_pkg::FLAGS_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state register
  assign resp_valid          = state.resp_valid;
  assign resp_abort          = state.resp_abort;
  assign resp_write_drop     = state.resp_write_drop;
  assign resp_cpl_abort      = state.resp_cpl_abort;
  assign xcache_done         = state.xcache_done;
  assign xcache_access_fault = state.xcache_access_fault;
  assign err_status          = state.flags;
  assign fault_addr          = state.addr;
  assign fault_req_id        = state.id;
  assign fault_type          = state.typ;
  assign fault_ram_addr      = state.ram;
  assign fault_logged        = state.logged;
  assign irq                 = state.irq;

endmodule // io_translation_fault_handler

// >>> tb/fault_handler_monitor.sv
/*
  Checker for the translation fault handler, bound to the handler's ports.
  Assumes one clock, sys_clk, and a synchronous active-high rst.
*/
`timescale 1ns/1ps
module fault_handler_monitor #(
  parameter int ADDR_W = 64,
  parameter int ID_W   = 16
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              req_valid,
  input wire logic              req_write,
  input wire logic              req_mode,
  input wire logic [ADDR_W-1:0] req_raw_va,
  input wire logic [ADDR_W-1:0] req_adj_va,
  input wire logic [ID_W-1:0]   req_id,
  input wire logic              key_check_fail,
  input wire logic              entry_invalid,
  input wire logic              xcache_req,
  input wire logic              xcache_enabled,
  input wire logic [11:0]       err_clear,
  input wire logic [11:0]       err_mask,
  input wire logic              resp_valid,
  input wire logic              resp_write_drop,
  input wire logic              resp_cpl_abort,
  input wire logic              xcache_access_fault,
  input wire logic [11:0]       err_status,
  input wire logic [ADDR_W-1:0] fault_addr,
  input wire logic [ID_W-1:0]   fault_req_id,
  input wire logic              irq
);
  // All checks share one clock and are muted while reset is held
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  resp_timing_a: assert property (req_valid |=> resp_valid) else $error("no answer to request");
  write_drop_a: assert property (req_valid && req_write && key_check_fail |=> resp_write_drop && !resp_cpl_abort)
    else $error("faulted write not dropped");
  read_abort_a: assert property (req_valid && !req_write && entry_invalid |=> resp_cpl_abort && err_status[3])
    else $error("faulted read not aborted");
  cache_access_a: assert property (xcache_req && xcache_enabled |=> xcache_access_fault && err_status[6])
    else $error("cache port access not refused");
  flag_sticky_a: assert property (err_status[0] && !err_clear[0] |=> err_status[0]) else $error("flag lost");
  flag_clear_a: assert property (err_clear[6] && !(xcache_req && xcache_enabled) |=> !err_status[6])
    else $error("flag not cleared");
  irq_mask_a: assert property (irq == |(err_status & $past(err_mask))) else $error("irq mismatch");
  legacy_log_a: assert property (req_valid && !req_mode && key_check_fail |=>
    fault_addr == $past(req_raw_va) && fault_req_id == $past(req_id)) else $error("legacy log wrong");
  hyper_log_a: assert property (req_valid && req_mode && entry_invalid |=> fault_addr == $past(req_adj_va))
    else $error("hypervisor log wrong");
endmodule // fault_handler_monitor
bind io_translation_fault_handler fault_handler_monitor #(.ADDR_W(ADDR_W), .ID_W(ID_W)) u_mon (.*);

// >>> tb/dma_requester_model.sv
/*
  Model of the PCI Express side: one translated DMA request most cycles.
  Assumes sys_clk and rst from the bench; sweep[3] forces hypervisor mode and page code sweep[2:0].
*/
`timescale 1ns/1ps
module dma_requester_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] sweep,
  output logic            req_valid,
  output logic            req_write,
  output logic            req_mode,
  output logic [63:0]     req_raw_va,
  output logic [63:0]     req_adj_va,
  output logic [15:0]     req_id,
  output logic [6:0]      req_type,
  output logic [8:0]      req_ram_addr,
  output logic [2:0]      req_page_size,
  output logic [10:0]     faults
);
  logic [31:0] f, g, h;
  // Fields change every cycle so an idle request never shows stale values
  task automatic step();
    f = $urandom;
    g = $urandom;
    h = $urandom & $urandom & $urandom;
    req_valid <= (rst === 1'h0) && (sweep[3] || f[1:0] != 2'h0);
    req_write <= f[2];
    req_mode <= sweep[3] | f[3];
    req_page_size <= sweep[3] ? sweep[2:0] : f[6:4];
    req_raw_va <= {$urandom, $urandom};
    req_adj_va <= {$urandom, $urandom};
    req_id <= f[31:16];
    req_type <= g[6:0];
    req_ram_addr <= g[15:7];
    faults <= {h[8:0], f[7] & f[8], g[31]}; // Sparse faults, miss, walk enable
  endtask
  // Drive at time zero, then just after every rising edge
  initial begin
    step();
    forever begin
      @(posedge sys_clk);
      step();
    end
  end
endmodule // dma_requester_model

// >>> tb/io_translation_fault_handler_tb.sv
/*
  Self-checking bench: random DMA traffic, cache port accesses, clears and masks,
  compared each cycle with a reference worked out here. Assumes a 200 MHz clock.
*/
`timescale 1ns/1ps
module io_translation_fault_handler_tb;
  logic sys_clk, rst, req_valid, req_write, req_mode, xcache_req, xcache_write, xcache_enabled;
  logic key_check_fail, mode_in_error, range_exceeded, entry_invalid, entry_denied, cache_parity_err;
  logic cache_miss, walk_enable, walk_unexpected, walk_failed, walk_parity_err, fault_logged, irq;
  logic resp_valid, resp_abort, resp_write_drop, resp_cpl_abort, xcache_done, xcache_access_fault;
  logic e_rv, e_ab, e_wd, e_ca, e_xd, e_xf, e_irq, e_log, t_on;
  logic [63:0] req_raw_va, req_adj_va, fault_addr, e_addr;
  logic [15:0] req_id, fault_req_id, e_id;
  logic [6:0]  req_type, fault_type, e_type;
  logic [8:0]  req_ram_addr, fault_ram_addr, e_ram;
  logic [2:0]  req_page_size;
  logic [3:0]  sweep;
  logic [10:0] faults;
  logic [11:0] err_clear, err_mask, err_status, e_st, d;
  logic [31:0] r;
  int          fails, n_checks;

  assign {key_check_fail, mode_in_error, range_exceeded, entry_invalid, entry_denied, cache_parity_err,
          walk_unexpected, walk_failed, walk_parity_err, cache_miss, walk_enable} = faults;
  io_translation_fault_handler dut (.*);
  dma_requester_model u_req (.*);

  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Reference: flags in handler bit order, gated by a present request
  always @(posedge sys_clk) begin
    d = {req_mode && !(req_page_size inside {3'h0, 3'h1, 3'h3, 3'h5}), walk_parity_err, walk_failed,
         walk_unexpected, cache_miss & ~walk_enable, 1'h0, cache_parity_err, entry_denied, entry_invalid,
         range_exceeded, mode_in_error, key_check_fail} & {12{req_valid}};
    {e_rv, e_ab, e_wd, e_ca, e_xd, e_xf} = {req_valid, |d, |d & req_write, |d & ~req_write,
                                            xcache_req, xcache_req & xcache_enabled};
    e_st = (e_st & ~err_clear) | d | {5'h00, e_xf, 6'h00};
    e_irq = |(e_st & err_mask);
    if (|d) begin
      {e_addr, e_id, e_type} = {req_mode ? req_adj_va : req_raw_va, req_id, req_type};
      e_ram = (d[4] | d[5]) ? req_ram_addr : 9'h000; // RAM address kept only for these two
      e_log = 1'h1;
    end
    // Log valid drops once no flag is left standing
    if (e_st == 12'h000) e_log = 1'h0;
    if (rst) {e_rv, e_ab, e_wd, e_ca, e_xd, e_xf, e_irq, e_log, e_st, e_addr, e_id, e_type, e_ram} = '0;
  end
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Outputs are settled by the falling edge
  always @(negedge sys_clk) if (t_on) begin
    chk("resp", {e_rv, e_ab, e_wd, e_ca}, {resp_valid, resp_abort, resp_write_drop, resp_cpl_abort});
    chk("xcache", {e_xd, e_xf}, {xcache_done, xcache_access_fault});
    chk("err_status", e_st, err_status);
    chk("irq", e_irq, irq);
    chk("fault_addr", e_addr, fault_addr);
    chk("fault_log", {e_id, e_type, e_ram}, {fault_req_id, fault_type, fault_ram_addr});
    chk("fault_logged", e_log, fault_logged);
  end
  task automatic test_done();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Random port traffic; clear pulses sparse so flags build up
  task automatic run(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      r = $urandom;
      {xcache_req, xcache_write, xcache_enabled} <= {r[0] & r[1], r[2], r[3]};
      err_clear <= r[27:16] & r[15:4] & 12'($urandom);
      err_mask <= 12'($urandom);
    end
  endtask
  initial begin
    void'($urandom(28755));
    {rst, t_on, sweep, xcache_req, xcache_write, xcache_enabled, err_clear, err_mask} = {1'h1, 31'h0};
    {fails, n_checks} = 0;
    repeat (2) @(posedge sys_clk);
    t_on = 1'h1;
    repeat (14) @(posedge sys_clk);
    rst <= 1'h0;
    run(3000);
    for (int p = 0; p < 8; p++) begin
      @(posedge sys_clk);
      sweep <= {1'h1, 3'(p)};
    end
    @(posedge sys_clk);
    {sweep, xcache_req, err_clear} <= {4'h0, 1'h0, 12'hFFF};
    @(posedge sys_clk);
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    run(500);
    test_done();
  end
  // Watchdog: run needs about 3530 cycles
  initial begin
    #(5 * 8000);
    fails++;
    test_done();
  end
endmodule // io_translation_fault_handler_tb
